// [design/epd_defs.svh]
// constants for the encoder pulse divider output block
`ifndef EPD_DEFS_SVH
`define EPD_DEFS_SVH

// register indices
`define EPD_REG_MODE      4'h0
`define EPD_REG_NUM       4'h1
`define EPD_REG_DEN       4'h2
`define EPD_REG_CFG       4'h3
`define EPD_REG_STATUS    4'h4

// reset values
`define EPD_MODE_RST      8'h01
`define EPD_NUM_RST       24'h00_2710
`define EPD_DEN_RST       24'h02_0000
`define EPD_CFG_RST       8'h0F

// mode field positions
`define EPD_SRC_LO        0
`define EPD_SRC_HI        1
`define EPD_PHASE_BIT     2
`define EPD_ZPOL_BIT      3

// source codes
`define EPD_SRC_MOTOR     2'h1
`define EPD_SRC_SECOND    2'h2
`define EPD_SRC_BYPASS    2'h3

// torque-limit output settings
`define EPD_TLIM_NORMAL   8'h0F
`define EPD_TLIM_INVERT   8'h10

// edges of one quadrature edge counted per revolution
`define EPD_EDGES_PER_REV 24'h02_0000

`endif

// [design/epd_pkg.sv]
// types for the encoder pulse divider output block
package epd_pkg;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } epd_quad_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } epd_bus_t;

  typedef enum logic [2:0] {
    EPD_ST_IDLE = 3'b001,
    EPD_ST_FWD  = 3'b010,
    EPD_ST_REV  = 3'b100
  } epd_step_t;

endpackage : epd_pkg

// [design/epd_quad_gen.sv]
// quadrature state generator stepped by forward/reverse pulses
`timescale 1ns/1ps
module epd_quad_gen
  import epd_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // step requests
  input  wire logic step_fwd,
  input  wire logic step_rev,
  input  wire logic b_leads,
  // outputs
  output logic      phase_a,
  output logic      phase_b
);

  logic [1:0] gray;
  logic [1:0] next_gray;
  epd_step_t  step;

  // ****************
  // next state
  // ****************
  always_comb begin
    step = EPD_ST_IDLE;
    if (step_fwd && !step_rev) begin
      step = EPD_ST_FWD;
    end else if (step_rev && !step_fwd) begin
      step = EPD_ST_REV;
    end
    next_gray = gray;
    case (step)
      EPD_ST_FWD: begin
        next_gray = {gray[0], ~gray[1]};
      end
      EPD_ST_REV: begin
        next_gray = {~gray[0], gray[1]};
      end
      default: begin
        next_gray = gray;
      end
    endcase
  end

  // ****************
  // registers
  // ****************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gray <= 2'h0;
    end else begin
      gray <= next_gray;
    end
  end

  // gray[0] leads gray[1] when stepping forward
  assign phase_a = b_leads ? gray[1] : gray[0];
  assign phase_b = b_leads ? gray[0] : gray[1];

endmodule : epd_quad_gen

// [design/epd_divider_out.sv]
// encoder pulse divider output stage with torque-limited status output
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "epd_defs.svh"

module epd_divider_out
  import epd_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // motor encoder edge events
  input  wire logic        mot_edge_fwd,
  input  wire logic        mot_edge_rev,
  input  wire logic        mot_index,
  // second encoder edge events
  input  wire logic        sec_edge_fwd,
  input  wire logic        sec_edge_rev,
  // external command pulse pair
  input  wire logic        cmd_pulse_a,
  input  wire logic        cmd_pulse_b,
  // torque limiter state
  input  wire logic        torque_limited_flag,
  // differential and open-collector outputs
  output logic             phase_a_diff_out,
  output logic             phase_a_diff_out_n,
  output logic             phase_b_diff_out,
  output logic             phase_b_diff_out_n,
  output logic             index_diff_out,
  output logic             index_diff_out_n,
  output logic             index_open_collector_out,
  // status contact, high means closed
  output logic             torque_limited_status_out
);

  // ****************
  // helper functions
  // ****************
  function automatic logic [24:0] acc_add(input logic [24:0] acc,
                                          input logic [23:0] inc);
    acc_add = acc + {1'b0, inc};
  endfunction : acc_add

  function automatic logic [31:0] rd_pad8(input logic [7:0] v);
    rd_pad8 = {24'h00_0000, v};
  endfunction : rd_pad8

  function automatic logic [31:0] rd_pad24(input logic [23:0] v);
    rd_pad24 = {8'h00, v};
  endfunction : rd_pad24

  // ****************
  // registers
  // ****************
  epd_bus_t    bus;
  logic [7:0]  divider_output_mode;
  logic [23:0] ratio_numerator_param;
  logic [23:0] ratio_denominator;
  logic [7:0]  tlim_setting;
  logic [7:0]  next_mode;
  logic [23:0] next_num;
  logic [23:0] next_den;
  logic [7:0]  next_tlim;
  logic [31:0] next_rdata;

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  always_comb begin
    next_mode = divider_output_mode;
    next_num  = ratio_numerator_param;
    next_den  = ratio_denominator;
    next_tlim = tlim_setting;
    if (bus.wr) begin
      case (bus.addr)
        `EPD_REG_MODE: begin
          next_mode = bus.wdata[7:0];
        end
        `EPD_REG_NUM: begin
          next_num = bus.wdata[23:0];
        end
        `EPD_REG_DEN: begin
          next_den = bus.wdata[23:0];
        end
        `EPD_REG_CFG: begin
          next_tlim = bus.wdata[7:0];
        end
        default: begin
          next_tlim = tlim_setting;
        end
      endcase
    end
  end

  // ****************
  // derived mode
  // ****************
  logic [1:0] src;
  logic       bypass;
  logic       b_leads;
  logic       zpol_fall;
  logic [23:0] inc;
  logic [23:0] modulus;
  logic        num_over;

  assign src       = divider_output_mode[`EPD_SRC_HI:`EPD_SRC_LO];
  assign bypass    = (src == `EPD_SRC_BYPASS);
  assign b_leads   = divider_output_mode[`EPD_PHASE_BIT];
  assign zpol_fall = divider_output_mode[`EPD_ZPOL_BIT];
  // numerator above denominator: emit numerator edges per revolution
  assign num_over = (ratio_numerator_param > ratio_denominator);
  assign inc      = ratio_numerator_param;
  assign modulus  = num_over ? `EPD_EDGES_PER_REV : ratio_denominator;

  // ****************
  // rate accumulator
  // ****************
  logic        in_fwd;
  logic        in_rev;
  logic [24:0] acc;
  logic [24:0] next_acc;
  logic        step_fwd;
  logic        step_rev;
  logic        next_step_fwd;
  logic        next_step_rev;
  logic [24:0] sum;

  always_comb begin
    in_fwd = 1'b0;
    in_rev = 1'b0;
    case (src)
      `EPD_SRC_MOTOR: begin
        in_fwd = mot_edge_fwd;
        in_rev = mot_edge_rev;
      end
      `EPD_SRC_SECOND: begin
        in_fwd = sec_edge_fwd;
        in_rev = sec_edge_rev;
      end
      default: begin
        in_fwd = 1'b0;
      end
    endcase
  end

  // each lone fwd or rev input edge adds num; each overflow past the modulus (den, or EPD_EDGES_PER_REV when num exceeds den) emits one output edge
  always_comb begin
    sum           = acc_add(acc, inc);
    next_acc      = acc;
    next_step_fwd = 1'b0;
    next_step_rev = 1'b0;
    if ((in_fwd ^ in_rev) && modulus != 24'h00_0000) begin
      if (sum >= {1'b0, modulus}) begin
        next_acc      = sum - {1'b0, modulus};
        next_step_fwd = in_fwd;
        next_step_rev = in_rev;
      end else begin
        next_acc = sum;
      end
    end
  end

  logic quad_a;
  logic quad_b;

  epd_quad_gen u_quad (
    .core_clk (core_clk),
    .rst      (rst),
    .step_fwd (step_fwd),
    .step_rev (step_rev),
    .b_leads  (b_leads),
    .phase_a  (quad_a),
    .phase_b  (quad_b)
  );

  // ****************
  // output selection
  // ****************
  epd_quad_t next_out;
  logic      next_tstat;

  always_comb begin
    if (bypass) begin
      next_out = '{a: cmd_pulse_a, b: cmd_pulse_b, z: 1'b0};
    end else begin
      next_out.a = quad_a;
      next_out.b = quad_b;
      next_out.z = (src == `EPD_SRC_MOTOR)
                   ? (mot_index ^ zpol_fall) : 1'b0;
    end
  end

  // ****************
  // status contact
  // ****************
  always_comb begin
    if (tlim_setting == `EPD_TLIM_INVERT) begin
      next_tstat = ~torque_limited_flag;
    end else if (tlim_setting == `EPD_TLIM_NORMAL) begin
      next_tstat = torque_limited_flag;
    end else begin
      next_tstat = 1'b0;
    end
  end

  // ****************
  // read data
  // ****************
  // status shows the a, b and index levels about to be registered on the pins, and the raw torque_limited_flag
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `EPD_REG_MODE:   next_rdata = rd_pad8(divider_output_mode);
        `EPD_REG_NUM:    next_rdata = rd_pad24(ratio_numerator_param);
        `EPD_REG_DEN:    next_rdata = rd_pad24(ratio_denominator);
        `EPD_REG_CFG:    next_rdata = rd_pad8(tlim_setting);
        `EPD_REG_STATUS: next_rdata = {28'h000_0000, next_out.z,
                                       next_out.b, next_out.a,
                                       torque_limited_flag};
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************
  // setting registers
  // ****************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divider_output_mode   <= `EPD_MODE_RST;
      ratio_numerator_param <= `EPD_NUM_RST;
      ratio_denominator     <= `EPD_DEN_RST;
      tlim_setting          <= `EPD_CFG_RST;
    end else begin
      divider_output_mode   <= next_mode;
      ratio_numerator_param <= next_num;
      ratio_denominator     <= next_den;
      tlim_setting          <= next_tlim;
    end
  end

  // ****************
  // accumulator registers
  // ****************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc      <= 25'h000_0000;
      step_fwd <= 1'b0;
      step_rev <= 1'b0;
    end else begin
      acc      <= next_acc;
      step_fwd <= next_step_fwd;
      step_rev <= next_step_rev;
    end
  end

  // ****************
  // output registers
  // ****************
  // complements are registered too so both legs switch on one edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata                 <= 32'h0000_0000;
      phase_a_diff_out          <= 1'b0;
      phase_a_diff_out_n        <= 1'b1;
      phase_b_diff_out          <= 1'b0;
      phase_b_diff_out_n        <= 1'b1;
      index_diff_out            <= 1'b0;
      index_diff_out_n          <= 1'b1;
      index_open_collector_out  <= 1'b0;
      torque_limited_status_out <= 1'b0;
    end else begin
      reg_rdata                 <= next_rdata;
      phase_a_diff_out          <= next_out.a;
      phase_a_diff_out_n        <= ~next_out.a;
      phase_b_diff_out          <= next_out.b;
      phase_b_diff_out_n        <= ~next_out.b;
      index_diff_out            <= next_out.z;
      index_diff_out_n          <= ~next_out.z;
      index_open_collector_out  <= next_out.z;
      torque_limited_status_out <= next_tstat;
    end
  end

endmodule : epd_divider_out

// [testbench/epd_divider_out_monitor.sv]
// port-level checks for the divider output block
`timescale 1ns/1ps
module epd_divider_out_monitor (
  // clock, reset, register port
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // sources
  input wire logic        mot_index,
  input wire logic        cmd_pulse_a,
  input wire logic        cmd_pulse_b,
  input wire logic        torque_limited_flag,
  // outputs
  input wire logic        phase_a_diff_out,
  input wire logic        phase_a_diff_out_n,
  input wire logic        phase_b_diff_out,
  input wire logic        index_diff_out,
  input wire logic        index_open_collector_out,
  input wire logic        torque_limited_status_out
);
  logic [7:0] m;
  logic [7:0] c;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // *****************
  // shadow settings
  // *****************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      m <= 8'h01;
      c <= 8'h0F;
    end else if (reg_wr) begin
      if (reg_addr == 4'h0) m <= reg_wdata[7:0];
      if (reg_addr == 4'h3) c <= reg_wdata[7:0];
    end
  end
  a_diff_a_pair: assert property (
    phase_a_diff_out_n == !phase_a_diff_out) else $error("a pair broken");
  a_quad_one_edge: assert property (
    !($changed(phase_a_diff_out) && $changed(phase_b_diff_out)))
    else $error("a and b moved together");
  a_index_motor: assert property (
    index_diff_out == $past((m[1:0] == 2'h1) && (mot_index ^ m[3])))
    else $error("index wrong");
  a_index_oc: assert property (
    index_open_collector_out == index_diff_out) else $error("oc index");
  a_status_norm: assert property (
    $past(c) == 8'h0F |-> torque_limited_status_out ==
    $past(torque_limited_flag)) else $error("status normal");
  a_status_inv: assert property (
    $past(c) == 8'h10 |-> torque_limited_status_out ==
    !$past(torque_limited_flag)) else $error("status inverted");
  a_bypass_copy: assert property (
    $past(m[1:0]) == 2'h3 |-> phase_a_diff_out == $past(cmd_pulse_a) &&
    phase_b_diff_out == $past(cmd_pulse_b)) else $error("bypass copy");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("rdata");
  a_mode_read: assert property (
    $past(reg_rd && reg_addr == 4'h0) |->
    reg_rdata == {24'h00_0000, $past(m)}) else $error("mode read");
endmodule : epd_divider_out_monitor

bind epd_divider_out epd_divider_out_monitor mon (.core_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mot_index,
  .cmd_pulse_a, .cmd_pulse_b, .torque_limited_flag, .phase_a_diff_out,
  .phase_a_diff_out_n, .phase_b_diff_out, .index_diff_out,
  .index_open_collector_out, .torque_limited_status_out);

// [testbench/epd_host_model.sv]
// host controller model decoding the differential quadrature pair
`timescale 1ns/1ps
module epd_host_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // differential receivers
  input  wire logic a_p,
  input  wire logic a_n,
  input  wire logic b_p,
  input  wire logic b_n,
  // decoded position, up when a leads b
  output int        pos
);
  logic a;
  logic b;
  logic pa;
  logic pb;
  assign a = a_p & !a_n;
  assign b = b_p & !b_n;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pa <= 1'b0;
      pb <= 1'b0;
      pos <= 0;
    end else begin
      pa <= a;
      pb <= b;
      if ((a != pa && a != pb) || (b != pb && b == pa)) pos <= pos + 1;
      else if (a != pa || b != pb) pos <= pos - 1;
    end
  end
endmodule : epd_host_model

// [testbench/tb_epd_divider_out.sv]
// self-checking bench for the divider output block
`timescale 1ns/1ps
module tb_epd_divider_out;
  logic        core_clk;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        mot_edge_fwd, mot_edge_rev, mot_index;
  logic        sec_edge_fwd, sec_edge_rev, cmd_pulse_a, cmd_pulse_b;
  logic        torque_limited_flag, torque_limited_status_out;
  logic        phase_a_diff_out, phase_a_diff_out_n;
  logic        phase_b_diff_out, phase_b_diff_out_n;
  logic        index_diff_out, index_diff_out_n, index_open_collector_out;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  int          pos;
  int          p0;
  epd_divider_out dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .mot_edge_fwd, .mot_edge_rev, .mot_index,
    .sec_edge_fwd, .sec_edge_rev, .cmd_pulse_a, .cmd_pulse_b,
    .torque_limited_flag, .phase_a_diff_out, .phase_a_diff_out_n,
    .phase_b_diff_out, .phase_b_diff_out_n, .index_diff_out,
    .index_diff_out_n, .index_open_collector_out,
    .torque_limited_status_out);
  epd_host_model host (.core_clk, .rst, .a_p(phase_a_diff_out),
    .a_n(phase_a_diff_out_n), .b_p(phase_b_diff_out),
    .b_n(phase_b_diff_out_n), .pos(pos));
  // *****************
  // tasks
  // *****************
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
    @(posedge core_clk);
  endtask : rd
  task automatic enc(input logic [7:0] md, input logic [3:0] w, input int e);
    wr(4'h0, {24'h00_0000, md});
    p0 = pos;
    repeat (8) begin
      {mot_edge_fwd, mot_edge_rev, sec_edge_fwd, sec_edge_rev} <= w;
      @(posedge core_clk);
    end
    {mot_edge_fwd, mot_edge_rev, sec_edge_fwd, sec_edge_rev} <= 4'h0;
    repeat (6) @(posedge core_clk);
    chk("steps", e, pos - p0);
  endtask : enc
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles > 2000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, mot_index} = '0;
    {cmd_pulse_a, cmd_pulse_b, torque_limited_flag} = 3'h0;
    {mot_edge_fwd, mot_edge_rev, sec_edge_fwd, sec_edge_rev} = 4'h0;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(4'h0, 32'h0000_0001);
    rd(4'h1, 32'h0000_2710);
    rd(4'h2, 32'h0002_0000);
    rd(4'h3, 32'h0000_000F);
    wr(4'h9, 32'h0000_00FF);
    rd(4'h9, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      wr(4'h3, (i < 2) ? 32'h0000_000F
                       : (i < 4) ? 32'h0000_0010 : 32'h0000_0020);
      torque_limited_flag <= i[0];
      repeat (2) @(posedge core_clk);
      #1;
      chk("status", (i < 2) ? i[0] : (i < 4) ? !i[0] : 1'b0,
        torque_limited_status_out);
    end
    wr(4'h1, 32'h0000_0001);
    wr(4'h2, 32'h0000_0002);
    enc(8'h01, 4'h8, 4);
    enc(8'h05, 4'h8, -4);
    enc(8'h01, 4'h4, -4);
    enc(8'h02, 4'h8, 0);
    enc(8'h02, 4'h2, 4);
    enc(8'h02, 4'h3, 0);
    mot_index <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, (i == 0) ? 32'h0000_0001
                        : (i == 1) ? 32'h0000_0009 : 32'h0000_0002);
      repeat (2) @(posedge core_clk);
      #1;
      chk("index", i == 0, index_open_collector_out);
      chk("index_n", i != 0, index_diff_out_n);
    end
    wr(4'h0, 32'h0000_000F);
    wr(4'h1, 32'h0000_0000);
    for (int i = 1; i < 4; i++) begin
      {cmd_pulse_b, cmd_pulse_a} <= 2'(i ^ (i >> 1));
      repeat (2) @(posedge core_clk);
      #1;
      chk("bypass", i ^ (i >> 1),
        {phase_b_diff_out, phase_a_diff_out});
    end
    rd(4'h4, 32'h0000_0005);
    conclude();
  end
endmodule : tb_epd_divider_out
